// *** rtl/bus_buffer_pkg.sv ***
// Constants, types and timing counts for the two-wire bus buffer connection control
//
// Behaviour
// - Enable low keeps backplane data and clock separated from card data and clock.
// - Enable low forces the connection status flag low.
// - Enable low suppresses stuck-bus recovery clocking on the card clock line.
// - Enable rising after a stuck-bus fault joins both pairs at once.
// - Accelerator select tied high turns all four accelerators off.
// - Accelerator select tied low turns all four accelerators on.
// - Accelerator select floating turns on only card-side accelerators.
// - Fault flag is driven low for bus stuck low, released high otherwise.
// - Status flag is high when segments are joined, low otherwise.
// - Timer runs while a card line is low; expiry faults and breaks connections.
// - After fault wait the delay, then up to sixteen card clock pulses.
// - Join needs backplane stop or idle plus both card lines high.
// - Card lines both high release the fault; reconnect by normal conditions or by an enable rise.
package bus_buffer_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS     = 50;
  localparam int STUCK_TIMEOUT_US   = 30000;
  localparam int BUS_IDLE_US        = 95;
  localparam int RECOVER_DELAY_US   = 40;
  localparam int RECOVER_FREQ_HZ    = 8500;
  localparam int MCLK_FREQ_HZ       = 1000000000 / MCLK_PERIOD_NS;
  // Longest-time style rounding for the timeout, least time rounds up for the delay
  localparam int STUCK_TIMEOUT_CYC  = STUCK_TIMEOUT_US * 1000 / MCLK_PERIOD_NS;
  localparam int BUS_IDLE_CYC       = BUS_IDLE_US * 1000 / MCLK_PERIOD_NS;
  localparam int RECOVER_DELAY_CYC  = (RECOVER_DELAY_US * 1000 + MCLK_PERIOD_NS - 1)
                                      / MCLK_PERIOD_NS;
  localparam int RECOVER_HALF_CYC   = MCLK_FREQ_HZ / (2 * RECOVER_FREQ_HZ);
  localparam int RECOVER_PULSES     = 16;
  localparam int TIMER_W            = 20;
  localparam int PULSE_W            = 5;
  localparam logic [1:0] BLANK_CYC  = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic card_clock_line;
    logic card_data_line;
    logic backplane_clock_line;
    logic backplane_data_line;
  } bus_lines_t;

  localparam bus_lines_t LINES_RESET = 4'h0;

  typedef enum logic [1:0] {
    ACC_FLOAT     = 2'h0,
    ACC_TIED_LOW  = 2'h1,
    ACC_TIED_HIGH = 2'h2
  } acc_sel_t;

  typedef enum logic [2:0] {
    ST_WAIT_JOIN = 3'h0,
    ST_JOINED    = 3'h1,
    ST_FAULT_DLY = 3'h2,
    ST_RECOVER   = 3'h3,
    ST_FAULT_END = 3'h4
  } conn_state_t;

endpackage

// *** rtl/two_wire_buffer_connect_control.sv ***
// Connection control of a two-wire bus buffer joining backplane and card segments
`timescale 1ns/1ns
module two_wire_buffer_connect_control #(
  parameter int STUCK_CYC   = bus_buffer_pkg::STUCK_TIMEOUT_CYC,
  parameter int IDLE_CYC    = bus_buffer_pkg::BUS_IDLE_CYC,
  parameter int HALF_CYC    = bus_buffer_pkg::RECOVER_HALF_CYC,
  parameter int DELAY_CYC   = bus_buffer_pkg::RECOVER_DELAY_CYC
) (
  input  wire logic                       mclk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       link_clk_i,
  input  wire logic                       enable_i,
  input  wire bus_buffer_pkg::acc_sel_t   acc_sel_i,
  input  wire bus_buffer_pkg::bus_lines_t line_level_i,
  output      bus_buffer_pkg::bus_lines_t line_drive_o,
  output      bus_buffer_pkg::bus_lines_t line_oe_o,
  output      bus_buffer_pkg::bus_lines_t accel_en_o,
  output      logic                       ready_o,
  output      logic                       fault_n_o
);

  // ----------------------------------------------------------------
  // Link domain: backplane clock edges mark bus activity
  // ----------------------------------------------------------------
  logic activity_tgl;

  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      activity_tgl <= 1'b0;
    end else begin
      activity_tgl <= ~activity_tgl;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers into the main clock domain
  // ----------------------------------------------------------------
  bus_buffer_pkg::bus_lines_t lines_s1;
  bus_buffer_pkg::bus_lines_t lines_s2;
  bus_buffer_pkg::bus_lines_t lines_prev;
  logic [2:0] en_sync;
  logic [2:0] act_sync;
  logic [1:0] acc_s1;
  logic [1:0] acc_s2;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lines_s1   <= bus_buffer_pkg::LINES_RESET;
      lines_s2   <= bus_buffer_pkg::LINES_RESET;
      lines_prev <= bus_buffer_pkg::LINES_RESET;
      en_sync    <= 3'h0;
      act_sync   <= 3'h0;
      acc_s1     <= 2'h0;
      acc_s2     <= 2'h0;
    end else begin
      lines_s1   <= line_level_i;
      lines_s2   <= lines_s1;
      lines_prev <= lines_s2;
      en_sync    <= {en_sync[1:0], enable_i};
      act_sync   <= {act_sync[1:0], activity_tgl};
      acc_s1     <= acc_sel_i;
      acc_s2     <= acc_s1;
    end
  end

  wire enable_on   = en_sync[1];
  wire enable_rise = en_sync[1] & ~en_sync[2];
  wire bp_activity = act_sync[1] ^ act_sync[2];
  wire card_high   = lines_s2.card_data_line & lines_s2.card_clock_line;
  wire bp_high     = lines_s2.backplane_data_line & lines_s2.backplane_clock_line;
  // Stop: data rises while clock stays high
  wire bp_stop     = lines_s2.backplane_data_line & ~lines_prev.backplane_data_line
                     & lines_s2.backplane_clock_line & lines_prev.backplane_clock_line;

  // ----------------------------------------------------------------
  // Stuck timer and backplane idle counter
  // ----------------------------------------------------------------
  logic [bus_buffer_pkg::TIMER_W-1:0] stuck_cnt;
  logic [bus_buffer_pkg::TIMER_W-1:0] idle_cnt;
  logic                               stop_seen;
  logic                               forced_join;
  logic                               fault_seen;
  bus_buffer_pkg::conn_state_t        state;
  bus_buffer_pkg::conn_state_t        next_state;

  wire stuck_expired = (stuck_cnt == STUCK_CYC[bus_buffer_pkg::TIMER_W-1:0]);
  wire bp_idle       = (idle_cnt == IDLE_CYC[bus_buffer_pkg::TIMER_W-1:0]);
  wire force_now     = enable_rise & fault_seen;
  wire join_ok       = enable_on & (stop_seen | bp_idle) & card_high;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stuck_cnt <= '0;
    end else if (card_high || force_now) begin
      stuck_cnt <= '0;
    end else if (!stuck_expired) begin
      stuck_cnt <= stuck_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_cnt <= '0;
    end else if (!bp_high || bp_activity) begin
      idle_cnt <= '0;
    end else if (!bp_idle) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // A stop is remembered until the join happens or the backplane gets busy again
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_seen <= 1'b0;
    end else if (bp_stop) begin
      stop_seen <= 1'b1;
    end else if (!bp_high || state == bus_buffer_pkg::ST_JOINED) begin
      stop_seen <= 1'b0;
    end
  end

  // Fault history: set by a timeout, spent by a forced join unless the expired timer still sees a card line low in that cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_seen <= 1'b0;
    end else if (stuck_expired && !card_high) begin
      fault_seen <= 1'b1;
    end else if (force_now) begin
      fault_seen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Connection state machine and recovery clocking
  // ----------------------------------------------------------------
  logic [bus_buffer_pkg::TIMER_W-1:0] rec_cnt;
  logic [bus_buffer_pkg::PULSE_W-1:0] pulse_cnt;
  logic                               rec_pull;

  // Counter runs 0 to HALF_LAST, so each half period lasts exactly HALF_CYC cycles
  localparam int HALF_LAST = HALF_CYC - 1;
  wire rec_tick   = (rec_cnt == HALF_LAST[bus_buffer_pkg::TIMER_W-1:0]);
  wire delay_done = (rec_cnt == DELAY_CYC[bus_buffer_pkg::TIMER_W-1:0]);
  wire pulses_done = (pulse_cnt == bus_buffer_pkg::RECOVER_PULSES[bus_buffer_pkg::PULSE_W-1:0]);
  wire timeout_hit = stuck_expired & ~card_high
                     & (state == bus_buffer_pkg::ST_JOINED
                        || state == bus_buffer_pkg::ST_WAIT_JOIN);

  always_comb begin
    next_state = state;
    unique case (state)
      bus_buffer_pkg::ST_WAIT_JOIN: begin
        if (timeout_hit) next_state = bus_buffer_pkg::ST_FAULT_DLY;
        else if (join_ok) next_state = bus_buffer_pkg::ST_JOINED;
      end
      bus_buffer_pkg::ST_JOINED: begin
        if (timeout_hit) next_state = bus_buffer_pkg::ST_FAULT_DLY;
        else if (!enable_on) next_state = bus_buffer_pkg::ST_WAIT_JOIN;
      end
      bus_buffer_pkg::ST_FAULT_DLY: begin
        if (card_high) next_state = bus_buffer_pkg::ST_WAIT_JOIN;
        else if (delay_done && enable_on) next_state = bus_buffer_pkg::ST_RECOVER;
      end
      bus_buffer_pkg::ST_RECOVER: begin
        if (card_high) next_state = bus_buffer_pkg::ST_WAIT_JOIN;
        else if (pulses_done) next_state = bus_buffer_pkg::ST_FAULT_END;
      end
      bus_buffer_pkg::ST_FAULT_END: begin
        if (card_high) next_state = bus_buffer_pkg::ST_WAIT_JOIN;
      end
      default: next_state = bus_buffer_pkg::ST_WAIT_JOIN;
    endcase
    if (force_now) next_state = bus_buffer_pkg::ST_JOINED;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= bus_buffer_pkg::ST_WAIT_JOIN;
    end else begin
      state <= next_state;
    end
  end

  // Pulses freeze while enable is low; the enable rise then forces a join instead of resuming recovery
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rec_cnt   <= '0;
      pulse_cnt <= '0;
      rec_pull  <= 1'b0;
    end else if (next_state != state) begin
      rec_cnt   <= '0;
      pulse_cnt <= '0;
      rec_pull  <= 1'b0;
    end else if (state == bus_buffer_pkg::ST_FAULT_DLY && !delay_done) begin
      rec_cnt   <= rec_cnt + 1'b1;
    end else if (state == bus_buffer_pkg::ST_RECOVER && enable_on) begin
      if (rec_tick) begin
        rec_cnt   <= '0;
        rec_pull  <= ~rec_pull;
        if (rec_pull) pulse_cnt <= pulse_cnt + 1'b1;
      end else begin
        rec_cnt   <= rec_cnt + 1'b1;
      end
    end else if (!enable_on) begin
      rec_pull  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pair joining: each side low pulls the other side low
  // ----------------------------------------------------------------
  wire joined = (state == bus_buffer_pkg::ST_JOINED) & enable_on;
  wire [1:0] bp_lv   = {lines_s2.backplane_clock_line, lines_s2.backplane_data_line};
  wire [1:0] card_lv = {lines_s2.card_clock_line, lines_s2.card_data_line};
  logic [1:0] drive_card;
  logic [1:0] drive_bp;
  logic [1:0] blank [2];

  // Blanking covers the synchroniser delay after a release, so the line we just let go
  // is not mistaken for a low driven from its own side.
  for (genvar p = 0; p < 2; p++) begin : g_pair
    wire next_drive_card = joined & ~bp_lv[p] & ~drive_bp[p]
                           & (drive_card[p] | (blank[p] == 2'h0));
    wire next_drive_bp   = joined & ~card_lv[p] & ~drive_card[p]
                           & (drive_bp[p] | (blank[p] == 2'h0));
    wire released        = (drive_card[p] & ~next_drive_card)
                           | (drive_bp[p] & ~next_drive_bp);

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        drive_card[p] <= 1'b0;
        drive_bp[p]   <= 1'b0;
        blank[p]      <= 2'h0;
      end else begin
        drive_card[p] <= next_drive_card;
        drive_bp[p]   <= next_drive_bp;
        blank[p]      <= released ? bus_buffer_pkg::BLANK_CYC
                         : (blank[p] != 2'h0) ? blank[p] - 2'h1 : 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  wire acc_bp   = (acc_s2 == bus_buffer_pkg::ACC_TIED_LOW);
  wire acc_card = (acc_s2 == bus_buffer_pkg::ACC_TIED_LOW)
                  | (acc_s2 == bus_buffer_pkg::ACC_FLOAT);
  wire joined_next = (next_state == bus_buffer_pkg::ST_JOINED) & enable_on;

  bus_buffer_pkg::bus_lines_t next_oe;
  bus_buffer_pkg::bus_lines_t next_acc;

  assign next_oe.backplane_data_line  = drive_bp[0];
  assign next_oe.backplane_clock_line = drive_bp[1];
  assign next_oe.card_data_line       = drive_card[0];
  assign next_oe.card_clock_line      = drive_card[1] | (rec_pull & enable_on);
  assign next_acc.backplane_data_line  = joined_next & acc_bp;
  assign next_acc.backplane_clock_line = joined_next & acc_bp;
  assign next_acc.card_data_line       = joined_next & acc_card;
  assign next_acc.card_clock_line      = joined_next & acc_card;

  wire next_fault = (next_state == bus_buffer_pkg::ST_FAULT_DLY)
                    | (next_state == bus_buffer_pkg::ST_RECOVER)
                    | (next_state == bus_buffer_pkg::ST_FAULT_END);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_drive_o <= bus_buffer_pkg::LINES_RESET;
      line_oe_o    <= bus_buffer_pkg::LINES_RESET;
      accel_en_o   <= bus_buffer_pkg::LINES_RESET;
      ready_o      <= 1'b0;
      fault_n_o    <= 1'b1;
    end else begin
      line_drive_o <= bus_buffer_pkg::LINES_RESET;
      line_oe_o    <= next_oe;
      accel_en_o   <= next_acc;
      ready_o      <= joined_next;
      fault_n_o    <= ~next_fault;
    end
  end

endmodule // two_wire_buffer_connect_control

// *** test/bus_buffer_partner.sv ***
// Open-drain bus wires with pull-ups and a backplane master that clocks frames
`timescale 1ns/1ns
module bus_buffer_partner (
  input  wire logic                       frame_i,
  input  wire bus_buffer_pkg::bus_lines_t pull_i,
  input  wire bus_buffer_pkg::bus_lines_t oe_i,
  output      bus_buffer_pkg::bus_lines_t level_o,
  output      logic                       link_clk_o
);
  logic clk_low = 1'b0;
  // Backplane clock stands released high between frames
  always #16 clk_low = frame_i ? ~clk_low : 1'b0;
  // A released line floats up to its pull-up level
  assign level_o = bus_buffer_pkg::bus_lines_t'(~(pull_i | oe_i | {2'h0, clk_low, 1'b0}));
  assign link_clk_o = level_o.backplane_clock_line;
endmodule // bus_buffer_partner

// *** test/test_two_wire_buffer_connect_control.sv ***
// Self-checking bench for the bus buffer connection control
`timescale 1ns/1ns
module test_two_wire_buffer_connect_control;
  localparam int STUCK = 200;
  localparam int IDLE  = 20;
  logic                       mclk_i;
  logic                       resetn_i;
  logic                       enable_i;
  logic                       frame;
  logic                       link_clk;
  logic                       ready_o;
  logic                       fault_n_o;
  bus_buffer_pkg::acc_sel_t   acc_sel_i;
  bus_buffer_pkg::bus_lines_t pull;
  bus_buffer_pkg::bus_lines_t level;
  bus_buffer_pkg::bus_lines_t line_oe_o;
  bus_buffer_pkg::bus_lines_t accel_en_o;
  logic [7:0]                 notes[$];
  logic [1:0]                 last;
  int                         err_count;
  int                         n_tests;
  int                         pulses;
  int                         mode;
  always #25 mclk_i = ~mclk_i;
  two_wire_buffer_connect_control #(.STUCK_CYC(STUCK), .IDLE_CYC(IDLE), .HALF_CYC(5),
      .DELAY_CYC(10)) two_wire_buffer_connect_control_i (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .link_clk_i(link_clk), .enable_i(enable_i),
    .acc_sel_i(acc_sel_i), .line_level_i(level), .line_drive_o(), .line_oe_o(line_oe_o),
    .accel_en_o(accel_en_o), .ready_o(ready_o), .fault_n_o(fault_n_o));
  bus_buffer_partner bus_buffer_partner_i (
    .frame_i(frame), .pull_i(pull), .oe_i(line_oe_o), .level_o(level), .link_clk_o(link_clk));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic note(input logic r, input logic f, input logic [3:0] a);
    notes.push_back({2'h0, r, f, a});
  endtask
  task automatic await(input logic r, input logic f, input int n);
    for (int i = 0; i < n && !(ready_o === r && fault_n_o === f); i++)
      @(negedge mclk_i);
    check("status", {6'h0, ready_o, fault_n_o}, {6'h0, r, f});
  endtask
  task automatic count_pulses(input int n);
    logic prev;
    prev = 1'b0;
    pulses = 0;
    repeat (n) begin
      @(negedge mclk_i);
      if (line_oe_o[3] && !prev)
        pulses++;
      prev = line_oe_o[3];
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [3:0] acc_exp(input int m);
    return (m == 1) ? 4'hF : (m == 0) ? 4'hC : 4'h0;
  endfunction
  // Each status change takes the oldest note once outputs have settled
  always @(negedge mclk_i) begin
    if (resetn_i && {ready_o, fault_n_o} !== last) begin
      last = {ready_o, fault_n_o};
      repeat (2) @(negedge mclk_i);
      if (notes.size() == 0)
        check("unexpected change", {2'h0, ready_o, fault_n_o, accel_en_o}, 8'hFF);
      else
        check("outputs", {2'h0, ready_o, fault_n_o, accel_en_o}, notes.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    results();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int off;
    mclk_i = 1'b0;
    resetn_i = 1'b0;
    enable_i = 1'b0;
    frame = 1'b0;
    acc_sel_i = bus_buffer_pkg::ACC_FLOAT;
    pull = bus_buffer_pkg::LINES_RESET;
    err_count = 0;
    n_tests = 0;
    last = 2'h1;
    void'($urandom(11147));
    off = $urandom % 3;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(negedge mclk_i);
    check("reset", {2'h0, ready_o, fault_n_o, line_oe_o}, 8'h10);
    for (int i = 0; i < 3; i++) begin
      mode = (i + off) % 3;
      @(posedge mclk_i);
      acc_sel_i <= bus_buffer_pkg::acc_sel_t'(mode);
      pull.card_data_line <= 1'b1;
      enable_i <= 1'b1;
      frame <= 1'b1;
      repeat ($urandom_range(30, 5)) @(posedge mclk_i);
      frame <= 1'b0;
      repeat (IDLE * 3) @(negedge mclk_i);
      check("join while card busy", {7'h0, ready_o}, 8'h0);
      note(1'b1, 1'b1, acc_exp(mode));
      @(posedge mclk_i);
      pull.card_data_line <= 1'b0;
      await(1'b1, 1'b1, IDLE + 20);
      @(posedge mclk_i);
      pull.backplane_data_line <= 1'b1;
      repeat (6) @(negedge mclk_i);
      check("card data follows", {7'h0, line_oe_o.card_data_line}, 8'h1);
      @(posedge mclk_i);
      pull.backplane_data_line <= 1'b0;
      repeat (8) @(negedge mclk_i);
      note(1'b0, 1'b1, 4'h0);
      @(posedge mclk_i);
      enable_i <= 1'b0;
      await(1'b0, 1'b1, 10);
    end
    // Stuck card while disabled: fault but no clocking
    note(1'b0, 1'b0, 4'h0);
    @(posedge mclk_i);
    pull.card_data_line <= 1'b1;
    await(1'b0, 1'b0, STUCK + 20);
    count_pulses(210);
    check("clocking while disabled", 8'(pulses), 8'h0);
    note(1'b0, 1'b1, 4'h0);
    @(posedge mclk_i);
    pull.card_data_line <= 1'b0;
    await(1'b0, 1'b1, 10);
    // Forced join with the backplane still busy
    note(1'b1, 1'b1, acc_exp(mode));
    @(posedge mclk_i);
    frame <= 1'b1;
    repeat (3) @(posedge mclk_i);
    enable_i <= 1'b1;
    @(posedge mclk_i);
    frame <= 1'b0;
    await(1'b1, 1'b1, 7);
    // Stuck card while joined: fault, recovery clocking, normal rejoin only
    note(1'b0, 1'b0, 4'h0);
    @(posedge mclk_i);
    pull.card_data_line <= 1'b1;
    await(1'b0, 1'b0, STUCK + 20);
    count_pulses(210);
    check("recovery pulses", 8'(pulses), 8'(bus_buffer_pkg::RECOVER_PULSES));
    note(1'b0, 1'b1, 4'h0);
    note(1'b1, 1'b1, acc_exp(mode));
    @(posedge mclk_i);
    frame <= 1'b1;
    repeat (4) @(posedge mclk_i);
    pull.card_data_line <= 1'b0;
    await(1'b0, 1'b1, 10);
    repeat (40) @(negedge mclk_i);
    check("join while backplane busy", {7'h0, ready_o}, 8'h0);
    @(posedge mclk_i);
    frame <= 1'b0;
    await(1'b1, 1'b1, IDLE + 20);
    repeat (5) @(negedge mclk_i);
    check("notes left", 8'(notes.size()), 8'h0);
    results();
  end
endmodule // test_two_wire_buffer_connect_control

// *** test/two_wire_buffer_connect_control_sva.sv ***
// Assertions on the ports of the bus buffer connection control
`timescale 1ns/1ns
module two_wire_buffer_connect_control_sva #(
  parameter int STUCK_CYC = 200,
  parameter int HALF_CYC  = 5
) (
  input wire logic                       mclk_i,
  input wire logic                       resetn_i,
  input wire logic                       link_clk_i,
  input wire logic                       enable_i,
  input wire bus_buffer_pkg::acc_sel_t   acc_sel_i,
  input wire bus_buffer_pkg::bus_lines_t line_level_i,
  input wire bus_buffer_pkg::bus_lines_t line_drive_o,
  input wire bus_buffer_pkg::bus_lines_t line_oe_o,
  input wire bus_buffer_pkg::bus_lines_t accel_en_o,
  input wire logic                       ready_o,
  input wire logic                       fault_n_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [19:0] stuck_cnt;
  logic [19:0] hi_cnt;
  wire         acc_hi = (acc_sel_i == bus_buffer_pkg::ACC_TIED_HIGH);
  wire         acc_lo = (acc_sel_i == bus_buffer_pkg::ACC_TIED_LOW);
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stuck_cnt <= 20'h0;
      hi_cnt    <= 20'h0;
    end else begin
      stuck_cnt <= (&line_level_i[3:2]) ? 20'h0 : stuck_cnt + 20'h1;
      hi_cnt    <= line_oe_o[3] ? hi_cnt + 20'h1 : 20'h0;
    end
  end
  AST_EN_READY: assert property (!enable_i [*5] |-> !ready_o)
    else $error("ready high while disabled");
  AST_EN_ISOLATE: assert property (!enable_i [*6] |-> line_oe_o == 4'h0)
    else $error("line pulled while disabled");
  AST_ACC_HIGH: assert property (acc_hi [*5] |-> accel_en_o == 4'h0)
    else $error("accelerator on while tied high");
  AST_ACC_LOW: assert property ((ready_o && acc_lo) [*5] |-> $past(accel_en_o) == 4'hF)
    else $error("accelerators not all on");
  // Margin of eight covers the input synchronisers
  AST_STUCK_EXPIRE: assert property (stuck_cnt == STUCK_CYC + 8 |-> !fault_n_o)
    else $error("no fault after stuck time");
  AST_FAULT_BREAK: assert property ($fell(fault_n_o) |-> ##[0:2] (!ready_o && line_oe_o == 4'h0))
    else $error("connection kept on fault");
  AST_FAULT_RELEASE: assert property ((line_level_i[3:2] == 2'h3) [*6] |-> fault_n_o)
    else $error("fault held with card lines high");
  AST_RECOVER_DELAY: assert property ($fell(fault_n_o) |=> !line_oe_o[3] [*8])
    else $error("recovery clock too early");
  AST_RECOVER_WIDTH: assert property ($fell(line_oe_o[3]) && !fault_n_o |-> hi_cnt == HALF_CYC)
    else $error("recovery pulse width wrong");
  AST_DRIVE_ZERO: assert property (line_drive_o == 4'h0)
    else $error("open-drain value not low");
endmodule // two_wire_buffer_connect_control_sva

bind two_wire_buffer_connect_control two_wire_buffer_connect_control_sva #(
  .STUCK_CYC(STUCK_CYC), .HALF_CYC(HALF_CYC)) two_wire_buffer_connect_control_sva_i (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i), .enable_i(enable_i),
  .acc_sel_i(acc_sel_i), .line_level_i(line_level_i), .line_drive_o(line_drive_o),
  .line_oe_o(line_oe_o), .accel_en_o(accel_en_o), .ready_o(ready_o), .fault_n_o(fault_n_o));
